// ### hw/asram_ctrl.sv
`timescale 1ns/1ns
`include "asram_defs.svh"
`default_nettype none
module asram_ctrl
(
	input  wire logic                        CLOCK_I,
	input  wire logic                        RESET_I,
	input  wire logic                        CLK_EN_I,
	input  wire logic                        REQ_VALID_I,
	input  wire asram_pkg::asram_req_type    REQ_I,
	output logic                             REQ_READY_O,
	output logic                             RDATA_VALID_O,
	output logic [`ASRAM_DATA_W-1:0]         RDATA_O,
	output logic [`ASRAM_ADDR_W-1:0]         MEM_ADDR_O,
	output logic                             MEM_SEL_N_O,
	output logic                             MEM_OE_N_O,
	output logic                             MEM_WE_N_O,
	input  wire logic [`ASRAM_DATA_W-1:0]    MEM_DATA_I,
	output logic [`ASRAM_DATA_W-1:0]         MEM_DATA_O,
	output logic                             MEM_DATA_OE_O
);
	asram_pkg::asram_state_type state;
	asram_pkg::asram_state_type next_state;
	asram_pkg::asram_ctl_type   ctl;
	logic                       is_write;
	logic                       load;
	logic [3:0]                 load_count;
	logic                       done;
	logic                       take;

	// Timer load value; the done cycle itself counts as one
	function automatic logic [3:0] cycles(input int n);
		cycles = (n < 1) ? 4'h0 : 4'((n - 1));
	endfunction

	function automatic asram_pkg::asram_ctl_type strobes
	(
		input logic sel_bit,
		input logic oe_bit,
		input logic we_bit
	);
		strobes = '{sel_n: sel_bit, oe_n: oe_bit, we_n: we_bit};
	endfunction

	// A request is only taken in idle; anything offered while busy and withdrawn before idle is dropped
	assign take = (state == asram_pkg::ST_IDLE) && REQ_VALID_I;

	// One shared down counter times the write pulse, read window and bus turn
	asram_timer u_timer
	(
		.clk_i   (CLOCK_I),
		.rst_i   (RESET_I),
		.ce_i    (CLK_EN_I),
		.load_i  (load),
		.count_i (load_count),
		.done_o  (done)
	);

	// Timer loads: pulse length on a write take, read window in setup, bus turn after
	always_comb
	begin
		load = 1'b0;
		load_count = 4'h0;
		case (state)
			asram_pkg::ST_IDLE:
			begin
				load = REQ_VALID_I;
				if (REQ_I.write)
					load_count = cycles(`ASRAM_WR_CYC);
				else
					load_count = 4'h0;
			end
			asram_pkg::ST_RD_SETUP:
			begin
				load = 1'b1;
				load_count = cycles(`ASRAM_RD_CYC);
			end
			asram_pkg::ST_RD_WAIT, asram_pkg::ST_WR_END:
			begin
				load = done;
				load_count = cycles(`ASRAM_HZ_CYC);
			end
			default:
			begin
				load = 1'b0;
				load_count = 4'h0;
			end
		endcase
	end

	// Sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			asram_pkg::ST_IDLE:
				if (REQ_VALID_I)
					next_state = REQ_I.write ? asram_pkg::ST_WR_PULSE : asram_pkg::ST_RD_SETUP;
			asram_pkg::ST_RD_SETUP:
				next_state = asram_pkg::ST_RD_WAIT;
			asram_pkg::ST_RD_WAIT:
				if (done)
					next_state = asram_pkg::ST_TURN;
			asram_pkg::ST_WR_PULSE:
				if (done)
					next_state = asram_pkg::ST_WR_END;
			asram_pkg::ST_WR_END:
				next_state = asram_pkg::ST_TURN;
			// Turn gap lets the memory float the bus before we may drive again
			asram_pkg::ST_TURN:
				if (done)
					next_state = asram_pkg::ST_IDLE;
			default:
				next_state = asram_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			state <= asram_pkg::ST_IDLE;
		else if (CLK_EN_I)
			state <= next_state;
	end

	// Address is set a cycle before select falls on reads
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			MEM_ADDR_O <= 19'h00000;
		else if (CLK_EN_I && take)
			MEM_ADDR_O <= REQ_I.addr;
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			MEM_DATA_O <= 8'h00;
		else if (CLK_EN_I && take)
			MEM_DATA_O <= REQ_I.wdata;
	end

	// Kept so a capture can never flag a write as a read answer
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			is_write <= 1'b0;
		else if (CLK_EN_I && take)
			is_write <= REQ_I.write;
	end

	// Control strobes, registered so each pin comes from a flop
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			ctl <= strobes(1'b1, 1'b1, 1'b1);
		else if (CLK_EN_I)
		begin
			case (state)
				asram_pkg::ST_IDLE:
					// Write path: select and strobe fall together with output enable high
					if (REQ_VALID_I && REQ_I.write)
						ctl <= strobes(1'b0, 1'b1, 1'b0);
					else
						ctl <= strobes(1'b1, 1'b1, 1'b1);
				asram_pkg::ST_RD_SETUP:
					ctl <= strobes(1'b0, 1'b0, 1'b1);
				asram_pkg::ST_WR_PULSE:
					// Only the strobe rises; select and data stay for hold
					if (done)
						ctl <= strobes(1'b0, 1'b1, 1'b1);
				asram_pkg::ST_RD_WAIT:
					if (done)
						ctl <= strobes(1'b1, 1'b1, 1'b1);
				default:
					ctl <= strobes(1'b1, 1'b1, 1'b1);
			endcase
		end
	end

	assign MEM_SEL_N_O = ctl.sel_n;
	assign MEM_OE_N_O = ctl.oe_n;
	assign MEM_WE_N_O = ctl.we_n;

	// Data drive only in write states with output enable high, so no fight with the memory
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			MEM_DATA_OE_O <= 1'b0;
		else if (CLK_EN_I)
			MEM_DATA_OE_O <= (take && REQ_I.write)
				|| state == asram_pkg::ST_WR_PULSE;
	end

	// Read byte is taken while select is still low, before the memory may float
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			RDATA_O <= 8'h00;
		else if (CLK_EN_I && state == asram_pkg::ST_RD_WAIT && done)
			RDATA_O <= MEM_DATA_I;
	end

	// One-cycle answer strobe
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			RDATA_VALID_O <= 1'b0;
		else if (CLK_EN_I)
			RDATA_VALID_O <= (state == asram_pkg::ST_RD_WAIT) && done && !is_write;
	end

	// Ready is only a hint; a request held valid is taken on entering idle
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			REQ_READY_O <= 1'b0;
		else if (CLK_EN_I)
			REQ_READY_O <= (state == asram_pkg::ST_TURN && done)
				|| (state == asram_pkg::ST_IDLE && !REQ_VALID_I);
	end
endmodule
`default_nettype wire

// ### hw/asram_defs.svh
// Summary of operation
// - A byte is written when select and write strobe are both low, taking the data lines into the addressed place.
// - A write ends at the first rise of select or write strobe, and data timing is taken from that edge.
// - The controller must not drive data while the memory may still be driving it.
// - For a read the address must be valid no later than the fall of select.
`ifndef ASRAM_DEFS_SVH
`define ASRAM_DEFS_SVH
`define ASRAM_ADDR_W        19
`define ASRAM_DATA_W        8
`define ASRAM_CLK_PERIOD_NS 50
`define ASRAM_T_RC_NS       70
`define ASRAM_T_WC_NS       70
`define ASRAM_T_SCE_NS      60
`define ASRAM_T_PWE_NS      55
`define ASRAM_T_SD_NS       30
`define ASRAM_T_HZ_NS       25
`define ASRAM_CYC_UP(t)     (((t) + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_RD_CYC        `ASRAM_CYC_UP(`ASRAM_T_RC_NS)
`define ASRAM_WR_CYC        `ASRAM_CYC_UP(`ASRAM_T_SCE_NS)
`define ASRAM_HZ_CYC        `ASRAM_CYC_UP(`ASRAM_T_HZ_NS)
`endif

// ### hw/asram_pkg.sv
package asram_pkg;
	typedef struct packed
	{
		logic        write;
		logic [18:0] addr;
		logic [7:0]  wdata;
	} asram_req_type;
	typedef struct packed
	{
		logic       sel_n;
		logic       oe_n;
		logic       we_n;
	} asram_ctl_type;
	typedef enum logic [2:0] {ST_IDLE, ST_RD_SETUP, ST_RD_WAIT, ST_WR_PULSE, ST_WR_END, ST_TURN} asram_state_type;
endpackage

// ### hw/asram_timer.sv
`timescale 1ns/1ns
`default_nettype none
module asram_timer
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       load_i,
	input  wire logic [3:0] count_i,
	output logic            done_o
);
	logic [3:0] remaining;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			remaining <= 4'h0;
		else if (ce_i)
		begin
			if (load_i)
				remaining <= count_i;
			else if (remaining != 4'h0)
				remaining <= remaining - 4'h1;
		end
	end
	// Not gated by load, so a user may reload from done without a loop
	assign done_o = (remaining == 4'h0);
endmodule
`default_nettype wire

// ### test/asram_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module asram_ctrl_assertions
(
	input  wire logic        CLOCK_I,
	input  wire logic        RESET_I,
	input  wire logic        RDATA_VALID_O,
	input  wire logic [18:0] MEM_ADDR_O,
	input  wire logic [7:0]  MEM_DATA_O,
	input  wire logic        MEM_SEL_N_O,
	input  wire logic        MEM_OE_N_O,
	input  wire logic        MEM_WE_N_O,
	input  wire logic        MEM_DATA_OE_O
);
	default clocking @(posedge CLOCK_I);
	endclocking
	default disable iff (RESET_I);
	sequence rd_go;
		$fell(MEM_SEL_N_O) && !MEM_OE_N_O;
	endsequence
	sequence wr_on;
		!MEM_SEL_N_O && !MEM_WE_N_O;
	endsequence
	chk_no_fight: assert property (MEM_DATA_OE_O |-> MEM_OE_N_O)
		else $error("data driven while memory output on");
	chk_wr_drives: assert property (wr_on |-> MEM_DATA_OE_O && MEM_OE_N_O)
		else $error("write without data driven");
	chk_wr_steady: assert property (wr_on ##1 wr_on |-> $stable(MEM_DATA_O) && $stable(MEM_ADDR_O))
		else $error("write data moved in pulse");
	chk_addr_first: assert property (rd_go |-> $stable(MEM_ADDR_O))
		else $error("address late for read");
	chk_rd_answer: assert property (rd_go |-> ##[2:4] RDATA_VALID_O)
		else $error("read answer missing");
	chk_we_width: assert property ($fell(MEM_WE_N_O) |-> wr_on [*2])
		else $error("write pulse too short");
	chk_sel_last: assert property ($rose(MEM_SEL_N_O) |-> $past(MEM_WE_N_O))
		else $error("select rose before write strobe");
	chk_data_hold: assert property ($rose(MEM_WE_N_O) |-> MEM_DATA_OE_O && $stable(MEM_DATA_O))
		else $error("write data dropped at strobe rise");
endmodule
bind asram_ctrl asram_ctrl_assertions u_chk (.*);
`default_nettype wire

// ### test/asram_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
module asram_ctrl_test;
	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	logic                    valid = 1'b0;
	logic                    ce = 1'b1;
	asram_pkg::asram_req_type req = '0;
	logic                    ready, rvalid, sel_n, oe_n, we_n, doe;
	logic [7:0]              rdata, dout, mq;
	logic [18:0]             addr;
	wire  [7:0]              bus;
	int                      err_total = 0;
	int                      checked = 0;
	// Small wire delay keeps the zero hold of write data race free
	assign #1 bus = doe ? dout : mq;
	always #25 clk = ~clk;
	asram_ctrl DUT (.CLOCK_I(clk), .RESET_I(rst), .CLK_EN_I(ce), .REQ_VALID_I(valid), .REQ_I(req),
		.REQ_READY_O(ready), .RDATA_VALID_O(rvalid), .RDATA_O(rdata), .MEM_ADDR_O(addr),
		.MEM_SEL_N_O(sel_n), .MEM_OE_N_O(oe_n), .MEM_WE_N_O(we_n), .MEM_DATA_I(bus),
		.MEM_DATA_O(dout), .MEM_DATA_OE_O(doe));
	asram_mem_model mem (.sel_n_i(sel_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr),
		.data_i(bus), .data_o(mq), .drive_o());
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step;
		@(posedge clk);
		#2;
	endtask
	task automatic issue(input logic wr, input logic [18:0] a, input logic [7:0] d);
		for (int n = 0; n < 20 && ready !== 1'b1; n++) step();
		req = {wr, a, d};
		valid = 1'b1;
		step();
		valid = 1'b0;
	endtask
	task automatic rd(input logic [18:0] a, input logic [7:0] exp);
		issue(1'b0, a, 8'h00);
		for (int n = 0; n < 9 && rvalid !== 1'b1; n++) step();
		cmp("read strobe", 8'h01, {7'h00, rvalid});
		cmp("read byte", exp, rdata);
	endtask
	task automatic t_fill;
		logic [18:0] a [3] = '{19'h00000, 19'h7FFFF, 19'h55555};
		logic [7:0]  d [3] = '{8'h5A, 8'hA5, 8'hFF};
		foreach (a[i]) issue(1'b1, a[i], d[i]);
		foreach (a[i]) rd(a[i], d[i]);
		issue(1'b1, a[2], 8'h00);
		rd(a[2], 8'h00);
	endtask
	task automatic t_ignored;
		issue(1'b1, 19'h01234, 8'hA5);
		step();
		cmp("ready while busy", 8'h00, {7'h00, ready});
		req = {1'b1, 19'h01234, 8'h3C};
		valid = 1'b1;
		step();
		valid = 1'b0;
		rd(19'h01234, 8'hA5);
	endtask
	task automatic t_freeze;
		issue(1'b0, 19'h00000, 8'h00);
		ce = 1'b0;
		repeat (4) step();
		cmp("frozen strobe", 8'h00, {7'h00, rvalid});
		cmp("frozen select", 8'h01, {7'h00, sel_n});
		ce = 1'b1;
		for (int n = 0; n < 9 && rvalid !== 1'b1; n++) step();
		cmp("read strobe", 8'h01, {7'h00, rvalid});
		cmp("read byte", 8'h5A, rdata);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		err_total++;
		give_verdict();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		#2;
		rst = 1'b0;
		t_fill();
		t_ignored();
		t_freeze();
		give_verdict();
	end
endmodule
`default_nettype wire

// ### test/asram_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module asram_mem_model
(
	input  wire logic        sel_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic [18:0] addr_i,
	input  wire logic [7:0]  data_i,
	output logic [7:0]       data_o,
	output logic             drive_o
);
	logic [7:0] mem [0:19'h7FFFF];
	logic [7:0] last = 8'h00;
	wire        wr = !sel_n_i && !we_n_i;
	wire  [7:0] rd = mem[addr_i];
	assign drive_o = !sel_n_i && !oe_n_i && we_n_i;
	// Released lines show the inverse so a stale byte never reads as good
	assign data_o = drive_o ? rd : last;
	always @(negedge drive_o) last = ~rd;
	always @(negedge wr) mem[addr_i] = data_i;
endmodule
`default_nettype wire
